// file: rtl/wbc_regs.sv
`timescale 1ns/1ns
module wbc_regs (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       sdi_in,
  input  wire logic       soft_reset_in,
  input  wire logic       restart_in,
  input  wire logic [1:0] restart_trx_mode_in,
  input  wire logic       sleep_entry_in,
  input  wire logic       stop_entry_in,
  input  wire logic       failsafe_entry_in,
  input  wire logic       system_error_flag_in,
  input  wire logic       hw_watch_update_in,
  input  wire logic       hw_stop_disable_in,
  input  wire logic [2:0] hw_period_in,
  output logic            sdo_out,
  output logic      [7:0] watchdog_control_out,
  output logic      [7:0] bus_mode_out,
  output logic      [7:0] supply_control_out,
  output logic            watch_parity_ok_out,
  output logic            stop_watch_disable_bit0_out,
  output logic            watch_type_select_out,
  output logic            watch_start_on_bus_wake_out,
  output logic      [2:0] watch_period_select_out,
  output logic            selective_wake_out,
  output logic      [1:0] trx_mode_out,
  output logic            reg3_voltage_config_out,
  output logic            reg3_load_sharing_out
);

  typedef struct packed {
    logic [7:0] watch;
    logic [7:0] bus;
    logic [7:0] supply;
    logic       parity_ok;
  } wbc_reg_state_t;

  wbc_reg_state_t s;
  wbc_reg_state_t next_s;
  logic     [6:0] addr;
  logic           wr_strobe;
  logic     [7:0] wr_data;
  logic     [7:0] rd_data;
  logic     [1:0] trx_next;
  logic           hw_event;

  function automatic logic [7:0] read_mux(input logic [6:0] a, input wbc_reg_state_t r);
    case (a)
      wbc_pkg::ADDR_SUPPLY: read_mux = r.supply;
      wbc_pkg::ADDR_WATCH:  read_mux = r.watch;
      wbc_pkg::ADDR_BUS:    read_mux = r.bus;
      default:              read_mux = wbc_pkg::UNMAPPED_READ;
    endcase
  endfunction : read_mux

  // ==========================================
  // serial access and mode step
  wbc_spi_frame u_frame (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .sck_in        (sck_in),
    .cs_n_in       (cs_n_in),
    .sdi_in        (sdi_in),
    .rd_data_in    (rd_data),
    .addr_out      (addr),
    .wr_strobe_out (wr_strobe),
    .wr_data_out   (wr_data),
    .sdo_out       (sdo_out)
  );

  wbc_trx_step u_trx (
    .mode_in              (s.bus[1:0]),
    .sleep_entry_in       (sleep_entry_in),
    .stop_entry_in        (stop_entry_in),
    .system_error_flag_in (system_error_flag_in),
    .failsafe_entry_in    (failsafe_entry_in),
    .next_mode_out        (trx_next)
  );

  assign rd_data  = read_mux(addr, s);
  assign hw_event = failsafe_entry_in | sleep_entry_in | stop_entry_in;

  // ==========================================
  // register update; hardware events win over a same-cycle write
  always_comb begin
    next_s = s;
    if (soft_reset_in) begin
      next_s.watch  = wbc_pkg::WATCH_RESET;
      next_s.bus    = wbc_pkg::BUS_RESET;
      next_s.supply = s.supply & wbc_pkg::SUPPLY_SOFT_KEEP;
    end else if (restart_in) begin
      next_s.watch  = (s.watch & wbc_pkg::WATCH_RESTART_KEEP) | wbc_pkg::WATCH_RESTART_SET;
      next_s.bus    = {5'h00, s.bus[wbc_pkg::BUS_SWK_BIT], restart_trx_mode_in};
      next_s.supply = s.supply & wbc_pkg::SUPPLY_RESTART_KEEP;
    end else begin
      if (wr_strobe) begin
        case (addr)
          wbc_pkg::ADDR_WATCH:  next_s.watch  = wr_data & wbc_pkg::WATCH_WMASK;
          wbc_pkg::ADDR_BUS:    next_s.bus    = wr_data & wbc_pkg::BUS_WMASK;
          wbc_pkg::ADDR_SUPPLY: next_s.supply = wr_data & wbc_pkg::SUPPLY_WMASK;
          default:              next_s.watch  = s.watch;
        endcase
      end
      if (hw_watch_update_in) begin
        next_s.watch[wbc_pkg::WATCH_STOP_DIS_BIT] = hw_stop_disable_in;
        next_s.watch[2:0] = hw_period_in;
      end
      if (hw_event) begin
        // only the low two bits; selective wake stays host-owned
        next_s.bus[1:0] = trx_next;
      end
    end
    // parity flag only reports; the host owns the checksum bit
    next_s.parity_ok = wbc_pkg::wbc_even_parity(next_s.watch);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s.watch     <= wbc_pkg::WATCH_RESET;
      s.bus       <= wbc_pkg::BUS_RESET;
      s.supply    <= wbc_pkg::SUPPLY_POR;
      s.parity_ok <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // outputs, all straight from the state register
  assign watchdog_control_out        = s.watch;
  assign bus_mode_out                = s.bus;
  assign supply_control_out          = s.supply;
  assign watch_parity_ok_out         = s.parity_ok;
  assign stop_watch_disable_bit0_out = s.watch[wbc_pkg::WATCH_STOP_DIS_BIT];
  assign watch_type_select_out       = s.watch[wbc_pkg::WATCH_TYPE_BIT];
  assign watch_start_on_bus_wake_out = s.watch[wbc_pkg::WATCH_BUSWAKE_BIT];
  assign watch_period_select_out     = s.watch[2:0];
  assign selective_wake_out          = s.bus[wbc_pkg::BUS_SWK_BIT];
  assign trx_mode_out                = s.bus[1:0];
  assign reg3_voltage_config_out     = s.supply[7];
  assign reg3_load_sharing_out       = s.supply[3];

  // ==========================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic quiet;
  assign quiet = !soft_reset_in && !restart_in;

  a_reserved_read_zero: assert property (
    watchdog_control_out[3] == 1'b0 && bus_mode_out[7:3] == 5'h00)
    else $error("reserved bits not zero");

  a_por_load_values: assert property (@(posedge clk_in) disable iff (1'b0)
    !rst_n_in |=> watchdog_control_out == 8'h14 && bus_mode_out == 8'h00 && supply_control_out == 8'h00)
    else $error("power-on values wrong");

  a_soft_reset_values: assert property (
    soft_reset_in |=> watchdog_control_out == 8'h14 && bus_mode_out == 8'h00
      && supply_control_out == ($past(supply_control_out) & 8'h88))
    else $error("soft reset values wrong");

  a_restart_watch_keep: assert property (
    !soft_reset_in && restart_in |=> watchdog_control_out[3:0] == 4'h4 && !watchdog_control_out[6]
      && watchdog_control_out[7] == $past(watchdog_control_out[7])
      && watchdog_control_out[5:4] == $past(watchdog_control_out[5:4]))
    else $error("restart watchdog value wrong");

  a_restart_bus_mode: assert property (
    !soft_reset_in && restart_in |=> bus_mode_out[7:3] == 5'h00
      && trx_mode_out == $past(restart_trx_mode_in))
    else $error("restart bus mode wrong");

  a_sleep_normal_wake: assert property (
    quiet && sleep_entry_in && !failsafe_entry_in && !system_error_flag_in && trx_mode_out == 2'h3
      |=> trx_mode_out == 2'h1 && $stable(selective_wake_out))
    else $error("sleep from normal not wake capable");

  a_stop_rx_holds: assert property (
    quiet && stop_entry_in && !sleep_entry_in && !failsafe_entry_in && trx_mode_out == 2'h2
      |=> trx_mode_out == 2'h2)
    else $error("stop left receive only");

  a_idle_mode_holds: assert property (
    quiet && (sleep_entry_in || stop_entry_in) && !failsafe_entry_in && !trx_mode_out[1]
      |=> $stable(trx_mode_out))
    else $error("off or wake capable changed");

  a_failsafe_wakeable: assert property (
    quiet && failsafe_entry_in |=> trx_mode_out == 2'h1
      ##1 (trx_mode_out == 2'h1 || $past(wr_strobe) || $past(restart_in) || $past(soft_reset_in)))
    else $error("fail-safe not wake capable");

  a_swk_host_only: assert property (
    quiet && !(wr_strobe && addr == 7'h04) |=> $stable(selective_wake_out))
    else $error("selective wake changed by hardware");

  a_watch_write_type: assert property (
    quiet && wr_strobe && addr == 7'h03 && !hw_watch_update_in
      |=> watch_type_select_out == $past(wr_data[5]) && watch_start_on_bus_wake_out == $past(wr_data[4])
      && stop_watch_disable_bit0_out == $past(wr_data[6]))
    else $error("watchdog write not stored");

  a_watch_write_full: assert property (
    quiet && wr_strobe && addr == 7'h03 && !hw_watch_update_in
      |=> watchdog_control_out == ($past(wr_data) & 8'hF7))
    else $error("watchdog write not masked");

  a_bus_write_full: assert property (
    quiet && wr_strobe && addr == 7'h04 && !hw_event
      |=> bus_mode_out == ($past(wr_data) & 8'h07))
    else $error("bus mode write not stored");

  a_supply_write_full: assert property (
    quiet && wr_strobe && addr == 7'h02
      |=> supply_control_out == ($past(wr_data) & 8'hFB))
    else $error("supply write not stored");

  a_unmapped_ignored: assert property (
    quiet && wr_strobe && addr != 7'h02 && addr != 7'h03 && addr != 7'h04
      && !hw_event && !hw_watch_update_in
      |=> $stable(watchdog_control_out)
      && $stable(bus_mode_out)
      && $stable(supply_control_out))
    else $error("unmapped write changed a register");

  a_regs_hold: assert property (
    quiet && !wr_strobe && !hw_event && !hw_watch_update_in
      |=> $stable(watchdog_control_out)
      && $stable(bus_mode_out)
      && $stable(supply_control_out))
    else $error("register changed with no cause");

  a_events_keep_watch: assert property (
    quiet && hw_event && !wr_strobe && !hw_watch_update_in
      |=> $stable(watchdog_control_out))
    else $error("mode entry changed watchdog control");

  a_parity_report: assert property (
    watch_parity_ok_out == ~(^watchdog_control_out))
    else $error("parity report wrong");

  a_sleep_rx_wake: assert property (
    quiet && sleep_entry_in && !failsafe_entry_in && trx_mode_out == 2'h2
      |=> trx_mode_out == 2'h1)
    else $error("sleep from receive only not wake capable");

  a_sleep_error_holds: assert property (
    quiet && sleep_entry_in && !failsafe_entry_in && system_error_flag_in && trx_mode_out == 2'h3
      |=> trx_mode_out == 2'h3)
    else $error("sleep with system error left normal");

  a_stop_normal_holds: assert property (
    quiet && stop_entry_in && !sleep_entry_in && !failsafe_entry_in && trx_mode_out == 2'h3
      |=> trx_mode_out == 2'h3)
    else $error("stop left normal");

  a_restart_swk_kept: assert property (
    !soft_reset_in && restart_in
      |=> selective_wake_out == $past(selective_wake_out))
    else $error("restart changed selective wake");

  a_hw_watch_load: assert property (
    quiet && hw_watch_update_in
      |=> stop_watch_disable_bit0_out == $past(hw_stop_disable_in)
      && watch_period_select_out == $past(hw_period_in))
    else $error("hardware watchdog update not stored");

  a_hw_host_bits: assert property (
    quiet && hw_watch_update_in && !(wr_strobe && addr == 7'h03)
      |=> $stable(watch_type_select_out)
      && $stable(watch_start_on_bus_wake_out)
      && $stable(watchdog_control_out[7]))
    else $error("hardware update touched host bits");

  a_write_strobe_pulse: assert property (
    wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");

  c_watch_write: cover property (quiet && wr_strobe && addr == 7'h03);
  c_sleep_normal: cover property (sleep_entry_in && trx_mode_out == 2'h3);
  c_failsafe: cover property (failsafe_entry_in ##1 trx_mode_out == 2'h1);
  c_restart: cover property (restart_in && !soft_reset_in);
  c_stop_rx: cover property (stop_entry_in && trx_mode_out == 2'h2);

endmodule : wbc_regs

// file: rtl/wbc_pkg.sv
package wbc_pkg;

  // ==========================================
  // register addresses (7-bit frame address)
  localparam logic [6:0] ADDR_SUPPLY         = 7'h02;
  localparam logic [6:0] ADDR_WATCH          = 7'h03;
  localparam logic [6:0] ADDR_BUS            = 7'h04;

  // ==========================================
  // reset, restart and write masks
  localparam logic [7:0] WATCH_RESET         = 8'h14;
  localparam logic [7:0] WATCH_RESTART_KEEP  = 8'hB0;
  localparam logic [7:0] WATCH_RESTART_SET   = 8'h04;
  localparam logic [7:0] WATCH_WMASK         = 8'hF7;
  localparam logic [7:0] BUS_RESET           = 8'h00;
  localparam logic [7:0] BUS_WMASK           = 8'h07;
  localparam logic [7:0] SUPPLY_POR          = 8'h00;
  localparam logic [7:0] SUPPLY_SOFT_KEEP    = 8'h88;
  localparam logic [7:0] SUPPLY_RESTART_KEEP = 8'hD9;
  localparam logic [7:0] SUPPLY_WMASK        = 8'hFB;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // ==========================================
  // field positions
  localparam int unsigned WATCH_PARITY_BIT   = 7;
  localparam int unsigned WATCH_STOP_DIS_BIT = 6;
  localparam int unsigned WATCH_TYPE_BIT     = 5;
  localparam int unsigned WATCH_BUSWAKE_BIT  = 4;
  localparam int unsigned BUS_SWK_BIT        = 2;

  // ==========================================
  // frame layout: 8 address/direction bits then 8 data bits
  localparam logic [4:0] ADDR_BITS           = 5'h08;
  localparam logic [4:0] FRAME_BITS          = 5'h10;

  typedef enum logic [1:0] {
    TRX_OFF     = 2'h0,
    TRX_WAKE    = 2'h1,
    TRX_RX_ONLY = 2'h2,
    TRX_NORMAL  = 2'h3
  } wbc_trx_t;

  function automatic logic wbc_even_parity(input logic [7:0] value);
    wbc_even_parity = ~(^value);
  endfunction : wbc_even_parity

endpackage : wbc_pkg

// file: rtl/wbc_trx_step.sv
`timescale 1ns/1ns
module wbc_trx_step (
  input  wire logic [1:0] mode_in,
  input  wire logic       sleep_entry_in,
  input  wire logic       stop_entry_in,
  input  wire logic       system_error_flag_in,
  input  wire logic       failsafe_entry_in,
  output logic      [1:0] next_mode_out
);

  // ==========================================
  // automatic transceiver mode changes
  always_comb begin
    next_mode_out = mode_in;
    if (failsafe_entry_in) begin
      next_mode_out = wbc_pkg::TRX_WAKE;
    end else if (sleep_entry_in) begin
      if (mode_in == wbc_pkg::TRX_NORMAL && !system_error_flag_in) begin
        next_mode_out = wbc_pkg::TRX_WAKE;
      end else if (mode_in == wbc_pkg::TRX_RX_ONLY) begin
        next_mode_out = wbc_pkg::TRX_WAKE;
      end
    end else if (stop_entry_in) begin
      // receive only stays receive only; host must pick it beforehand
      next_mode_out = mode_in;
    end
    // off and wake capable fall through unchanged except on fail-safe entry
  end

endmodule : wbc_trx_step

// file: rtl/wbc_spi_frame.sv
`timescale 1ns/1ns
module wbc_spi_frame (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       sdi_in,
  input  wire logic [7:0] rd_data_in,
  output logic      [6:0] addr_out,
  output logic            wr_strobe_out,
  output logic      [7:0] wr_data_out,
  output logic            sdo_out
);

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ADDR = 3'b010,
    PH_DATA = 3'b100
  } wbc_phase_t;

  typedef struct packed {
    logic       sck_q;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [7:0] tx;
    logic       sdo;
    logic       wr;
    wbc_phase_t phase;
  } wbc_spi_state_t;

  wbc_spi_state_t s;
  wbc_spi_state_t next_s;
  logic           rise;
  logic           fall;

  assign rise          = sck_in & ~s.sck_q;
  assign fall          = ~sck_in & s.sck_q;
  assign addr_out      = (s.cnt == wbc_pkg::FRAME_BITS) ? s.sh[15:9] : s.sh[7:1];
  assign wr_data_out   = s.sh[7:0];
  assign wr_strobe_out = s.wr;
  assign sdo_out       = s.sdo;

  // ==========================================
  // frame engine
  always_comb begin
    next_s       = s;
    next_s.sck_q = sck_in;
    next_s.wr    = 1'b0;
    case (s.phase)
      PH_IDLE: begin
        if (!cs_n_in) begin
          next_s.phase = PH_ADDR;
          next_s.cnt   = 5'h00;
          next_s.sdo   = 1'b0;
        end
      end
      PH_ADDR: begin
        if (cs_n_in) begin
          next_s.phase = PH_IDLE;
        end else if (rise) begin
          next_s.sh  = {s.sh[14:0], sdi_in};
          next_s.cnt = s.cnt + 5'h01;
          if (s.cnt == wbc_pkg::ADDR_BITS - 5'h01) begin
            next_s.phase = PH_DATA;
          end
        end
      end
      PH_DATA: begin
        if (cs_n_in) begin
          // write takes effect only at frame end, so readout is the old value
          next_s.wr    = (s.cnt == wbc_pkg::FRAME_BITS) & s.sh[8];
          next_s.phase = PH_IDLE;
        end else if (rise && s.cnt != wbc_pkg::FRAME_BITS) begin
          next_s.sh  = {s.sh[14:0], sdi_in};
          next_s.cnt = s.cnt + 5'h01;
        end else if (s.cnt == wbc_pkg::ADDR_BITS) begin
          next_s.tx  = rd_data_in;
          next_s.sdo = rd_data_in[7];
        end else if (fall) begin
          next_s.sdo = s.tx[6];
          next_s.tx  = {s.tx[6:0], 1'b0};
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s       <= '0;
      s.phase <= PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

endmodule : wbc_spi_frame

// file: verification/wbc_host_model.sv
`timescale 1ns/1ns
module wbc_host_model (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      sdi_out
);
  // ==========================================
  // serial master: sck half period 4 clk, well above the 3 clk floor
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b0;
  end

  // ==========================================
  // one frame: 7 address bits, direction, 8 data, msb first
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d,
                       input int nbits, output logic [7:0] rdata);
    logic [15:0] word;
    word  = {a, w, d};
    rdata = 8'h00;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      sdi_out = word[15-k];
      repeat (4) @(negedge clk_in);
      if (k >= 8) rdata[15-k] = sdo_in;
      sck_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sck_out = 1'b0;
    end
    cs_n_out = 1'b1;
    // released data line: never leave the last bit standing
    sdi_out = ~sdi_out;
    repeat (4) @(negedge clk_in);
  endtask : frame
endmodule : wbc_host_model

// file: verification/wbc_regs_tb.sv
`timescale 1ns/1ns
module wbc_regs_tb;
  logic       clk_in = 1'b0;
  logic       rst_n_in, sck_in, cs_n_in, sdi_in, sdo_out;
  logic       soft_reset_in, restart_in, sleep_entry_in, stop_entry_in, failsafe_entry_in;
  logic       system_error_flag_in, hw_watch_update_in, hw_stop_disable_in;
  logic [1:0] restart_trx_mode_in, trx_mode_out;
  logic [2:0] hw_period_in, watch_period_select_out;
  logic [7:0] watchdog_control_out, bus_mode_out, supply_control_out;
  logic       watch_parity_ok_out, stop_watch_disable_bit0_out, watch_type_select_out;
  logic       watch_start_on_bus_wake_out, selective_wake_out, reg3_voltage_config_out, reg3_load_sharing_out;
  logic [5:0] evt;
  logic [7:0] m_wd, m_bus, m_sup, d, r;
  logic [31:0] b;
  int         seed, error_cnt, cmp_count, cyc;

  assign {hw_watch_update_in, restart_in, soft_reset_in, failsafe_entry_in, stop_entry_in, sleep_entry_in} = evt;

  always #5 clk_in = ~clk_in;

  wbc_regs dut (.clk_in, .rst_n_in, .sck_in, .cs_n_in, .sdi_in, .soft_reset_in, .restart_in,
    .restart_trx_mode_in, .sleep_entry_in, .stop_entry_in, .failsafe_entry_in, .system_error_flag_in,
    .hw_watch_update_in, .hw_stop_disable_in, .hw_period_in, .sdo_out, .watchdog_control_out, .bus_mode_out,
    .supply_control_out, .watch_parity_ok_out, .stop_watch_disable_bit0_out, .watch_type_select_out,
    .watch_start_on_bus_wake_out, .watch_period_select_out, .selective_wake_out, .trx_mode_out,
    .reg3_voltage_config_out, .reg3_load_sharing_out);

  wbc_host_model host (.clk_in(clk_in), .sdo_in(sdo_out), .sck_out(sck_in), .cs_n_out(cs_n_in), .sdi_out(sdi_in));

  // ==========================================
  // checking and expectation helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  function automatic logic [1:0] nxt(input logic [1:0] m, input logic [5:0] sel, input logic se);
    if (sel[2]) return 2'h1;
    if (sel[0] && (m == 2'h2 || (m == 2'h3 && !se))) return 2'h1;
    return m;
  endfunction : nxt

  task automatic check_all();
    chk(watchdog_control_out, m_wd);
    chk(bus_mode_out, m_bus);
    chk(supply_control_out, m_sup);
    chk({watch_parity_ok_out, stop_watch_disable_bit0_out, watch_type_select_out, watch_start_on_bus_wake_out,
         1'b0, watch_period_select_out}, {~^m_wd, m_wd[6:0]});
    chk({3'h0, reg3_voltage_config_out, reg3_load_sharing_out, selective_wake_out, trx_mode_out},
        {3'h0, m_sup[7], m_sup[3], m_bus[2:0]});
  endtask : check_all

  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] dv, input logic [7:0] old);
    logic [7:0] rd;
    host.frame(a, w, dv, 16, rd);
    chk(rd, old);
  endtask : xfer

  task automatic ev(input logic [5:0] sel);
    @(negedge clk_in);
    evt = sel;
    @(negedge clk_in);
    evt = 6'h00;
    repeat (2) @(negedge clk_in);
  endtask : ev

  // ==========================================
  // hang guard, well above the roughly 9k cycles needed
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    seed = 32'h8B3C1D14;
    {rst_n_in, evt, system_error_flag_in, hw_stop_disable_in, hw_period_in, restart_trx_mode_in} = '0;
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    m_wd = 8'h14;
    m_bus = 8'h00;
    m_sup = 8'h00;
    check_all();
    for (int i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      d[7] = ^d[6:0] ^ (i == 5);
      xfer(wbc_pkg::ADDR_WATCH, 1'b1, d, m_wd);
      m_wd = d & wbc_pkg::WATCH_WMASK;
      d = 8'($random(seed));
      xfer(wbc_pkg::ADDR_BUS, 1'b1, d, m_bus);
      m_bus = d & wbc_pkg::BUS_WMASK;
      check_all();
    end
    xfer(7'h05, 1'b1, 8'hFF, 8'h00);
    host.frame(wbc_pkg::ADDR_WATCH, 1'b1, 8'h00, 15, r);
    chk(r, {m_wd[7:1], 1'b0});
    xfer(wbc_pkg::ADDR_WATCH, 1'b0, 8'h00, m_wd);
    check_all();
    // every mode under sleep, stop and fail-safe, error flag both ways
    for (int i = 0; i < 32; i++) begin
      b = $random(seed);
      d = {5'h00, b[0], 2'(i)};
      xfer(wbc_pkg::ADDR_BUS, 1'b1, d, m_bus);
      m_bus = d;
      system_error_flag_in = i[4];
      evt = 6'h00;
      ev((i[3:2] == 2'h1) ? 6'h02 : (i[3:2] == 2'h2) ? 6'h04 : 6'h01);
      m_bus[1:0] = nxt(d[1:0], (i[3:2] == 2'h1) ? 6'h02 : (i[3:2] == 2'h2) ? 6'h04 : 6'h01, i[4]);
      check_all();
    end
    b = $random(seed);
    hw_stop_disable_in = b[3];
    hw_period_in = b[2:0];
    ev(6'h20);
    m_wd = {m_wd[7], b[3], m_wd[5:3], b[2:0]};
    check_all();
    xfer(wbc_pkg::ADDR_SUPPLY, 1'b1, 8'hFF, m_sup);
    m_sup = 8'hFB;
    ev(6'h08);
    m_wd = 8'h14;
    m_bus = 8'h00;
    m_sup = m_sup & wbc_pkg::SUPPLY_SOFT_KEEP;
    check_all();
    xfer(wbc_pkg::ADDR_WATCH, 1'b1, 8'hB7, m_wd);
    xfer(wbc_pkg::ADDR_BUS, 1'b1, 8'hFF, m_bus);
    xfer(wbc_pkg::ADDR_SUPPLY, 1'b1, 8'hFF, m_sup);
    restart_trx_mode_in = 2'($random(seed));
    ev(6'h10);
    m_wd = 8'hB4;
    m_bus = {5'h00, 1'b1, restart_trx_mode_in};
    m_sup = 8'hFB & wbc_pkg::SUPPLY_RESTART_KEEP;
    check_all();
    // power-on in mid-run must also drop the supply bits a soft reset keeps
    @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    m_wd = 8'h14;
    m_bus = 8'h00;
    m_sup = 8'h00;
    check_all();
    xfer(wbc_pkg::ADDR_WATCH, 1'b0, 8'h00, m_wd);
    end_of_test();
  end
endmodule : wbc_regs_tb
